// >>> design/ast_pkg.sv
// Package for the asynchronous serial transmitter: register map, fields, timing.
// Assumes a 32-bit APB master on the same clock as the transmitter.
package ast_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // transmit_control_reg
  localparam logic [7:0] ADDR_DATA    = 8'h04;  // tx_holding_buffer (write)
  localparam logic [7:0] ADDR_DIVISOR = 8'h08;  // baud_divisor
  localparam logic [7:0] ADDR_FLAGS   = 8'h0C;  // periph_irq_flags_one
  localparam logic [7:0] ADDR_ENABLES = 8'h10;  // periph_irq_enables_one
  localparam logic [7:0] ADDR_POWER   = 8'h14;  // sleep request

  // ==========================================================================
  // Control, flag and power register fields
  localparam int CTRL_NINTH_DATA = 0;
  localparam int CTRL_SHIFT_EMPT = 1;
  localparam int CTRL_HIGH_SPEED = 2;
  localparam int CTRL_CLOCKED    = 4;
  localparam int CTRL_TX_ENABLE  = 5;
  localparam int CTRL_NINE_BIT   = 6;
  localparam int FLAG_BUF_EMPTY  = 4;
  localparam int POWER_SLEEP     = 0;

  localparam logic [7:0] CTRL_RESET    = 8'h02;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;

  // ==========================================================================
  // Oversampling and frame sizes
  localparam logic [5:0] OVS_HIGH     = 6'h0F;  // x16 minus one
  localparam logic [5:0] OVS_LOW      = 6'h3F;  // x64 minus one
  localparam logic [3:0] BITS_EIGHT   = 4'h8;
  localparam logic [3:0] BITS_NINE    = 4'h9;

  typedef enum logic [3:0] {
    AST_IDLE  = 4'b0001,
    AST_START = 4'b0010,
    AST_DATA  = 4'b0100,
    AST_STOP  = 4'b1000
  } ast_state_e;

  typedef struct packed {
    logic [8:0] data;
    logic       loaded;
  } ast_word_s;

endpackage : ast_pkg

// >>> design/ast_transmitter.sv
// Asynchronous serial transmitter with an APB register slave.
// Assumes one 50 MHz clock; i_nrst from outside, synchronised here.
//
// Summary of operation
// - Frame: start bit, eight or nine data bits, one stop bit, NRZ.
// - Data bits shifted out least significant bit first.
// - Dedicated 8-bit baud divider sets bit timing.
// - Baud clock is x16 of bit rate when high-speed set, else x64.
// - Transmitter shares format and baud setting, runs independently.
// - No parity hardware; software may use the ninth bit.
// - Serial operation halts while the device sleeps.
// - Asynchronous mode applies when clocked-mode select bit is zero.
// - Shift register loads holding buffer only after stop bit is sent.
// - Buffer-empty flag sets two cycles after buffer moves to shifter.
// - Buffer-empty flag ignores enable, not software clearable, cleared by data write.
// - Shift-empty bit follows shifter state one cycle later; no interrupt.
// - Setting transmit enable with the holding buffer empty sets buffer-empty flag.
// - Frame starts only with data buffered and a baud shift tick.
// - Writing data before setting enable also starts transmission.
// - Write to idle shifter moves across at the next shift tick, allowing a queued second word.
// - Clearing enable mid-frame aborts, resets, and releases the pin.
// - Nine-bit select adds the ninth data bit from the control register.
// - The shift register is not software visible.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ast_transmitter (
  input  wire logic        i_ref_clk,  // 50 MHz clock
  input  wire logic        i_nrst,     // Async reset, active low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB write
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  output logic             o_tx_out,   // serial_out_pin level
  output logic             o_tx_oe     // serial_out_pin drive enable
);

  // ==========================================================================
  // Reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // Shift toward the line; the LSB leaves first
  function automatic logic [8:0] shr(input logic [8:0] v);
    shr = {1'b0, v[8:1]};
  endfunction : shr

  // ==========================================================================
  // APB decode; zero wait states
  logic acc;
  logic wr;
  logic mapped;
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign mapped  = hit(paddr, ast_pkg::ADDR_CTRL) | hit(paddr, ast_pkg::ADDR_DATA)
                 | hit(paddr, ast_pkg::ADDR_DIVISOR) | hit(paddr, ast_pkg::ADDR_FLAGS)
                 | hit(paddr, ast_pkg::ADDR_ENABLES) | hit(paddr, ast_pkg::ADDR_POWER);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  logic       wr_ctrl;
  logic       wr_data;
  assign wr_ctrl = wr & hit(paddr, ast_pkg::ADDR_CTRL);
  assign wr_data = wr & hit(paddr, ast_pkg::ADDR_DATA);

  // ==========================================================================
  // Software-written settings
  logic       tx_enable_bit_q;
  logic       nine_bit_select_q;
  logic       ninth_data_bit_q;
  logic       baud_high_speed_q;
  logic       clocked_mode_q;
  logic [7:0] baud_divisor_q;
  logic       tx_irq_enable_q;
  logic       sleep_q;

  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_enable_bit_q   <= ast_pkg::CTRL_RESET[ast_pkg::CTRL_TX_ENABLE];
      nine_bit_select_q <= ast_pkg::CTRL_RESET[ast_pkg::CTRL_NINE_BIT];
      ninth_data_bit_q  <= ast_pkg::CTRL_RESET[ast_pkg::CTRL_NINTH_DATA];
      baud_high_speed_q <= ast_pkg::CTRL_RESET[ast_pkg::CTRL_HIGH_SPEED];
      clocked_mode_q    <= ast_pkg::CTRL_RESET[ast_pkg::CTRL_CLOCKED];
      baud_divisor_q    <= ast_pkg::DIVISOR_RESET;
      tx_irq_enable_q   <= 1'b0;
      sleep_q           <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        tx_enable_bit_q   <= pwdata[ast_pkg::CTRL_TX_ENABLE];
        nine_bit_select_q <= pwdata[ast_pkg::CTRL_NINE_BIT];
        ninth_data_bit_q  <= pwdata[ast_pkg::CTRL_NINTH_DATA];
        baud_high_speed_q <= pwdata[ast_pkg::CTRL_HIGH_SPEED];
        clocked_mode_q    <= pwdata[ast_pkg::CTRL_CLOCKED];
      end
      if (wr & hit(paddr, ast_pkg::ADDR_DIVISOR)) begin
        baud_divisor_q <= pwdata[7:0];
      end
      if (wr & hit(paddr, ast_pkg::ADDR_ENABLES)) begin
        tx_irq_enable_q <= pwdata[ast_pkg::FLAG_BUF_EMPTY];
      end
      if (wr & hit(paddr, ast_pkg::ADDR_POWER)) begin
        sleep_q <= pwdata[ast_pkg::POWER_SLEEP];
      end
    end
  end

  // Clocked mode is not built; the line is only driven in asynchronous mode
  logic run;
  assign run = tx_enable_bit_q & ~clocked_mode_q;

  // ==========================================================================
  // Baud generator: divider then oversampling prescaler
  logic [7:0] baud_cnt_q;
  logic [5:0] ovs_cnt_q;
  logic       baud_tick;
  logic       shift_tick;
  assign baud_tick  = run & ~sleep_q & (baud_cnt_q == 8'h00);
  assign shift_tick = baud_tick & (ovs_cnt_q == 6'h00);

  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      baud_cnt_q <= 8'h00;
      ovs_cnt_q  <= 6'h00;
    end else if (!run) begin
      baud_cnt_q <= baud_divisor_q;
      ovs_cnt_q  <= 6'h00;
    end else if (!sleep_q) begin
      if (baud_tick) begin
        baud_cnt_q <= baud_divisor_q;
        if (ovs_cnt_q == 6'h00) begin
          ovs_cnt_q <= baud_high_speed_q ? ast_pkg::OVS_HIGH : ast_pkg::OVS_LOW;
        end else begin
          ovs_cnt_q <= ovs_cnt_q - 6'h01;
        end
      end else begin
        baud_cnt_q <= baud_cnt_q - 8'h01;
      end
    end
  end

  // ==========================================================================
  // Holding buffer and hidden shift register
  ast_pkg::ast_word_s hold_q;
  ast_pkg::ast_state_e state_q;
  logic [8:0]         tx_shift_reg_q;
  logic [3:0]         bit_cnt_q;
  logic [3:0]         frame_bits_q;
  logic               tx_out_q;
  logic               load;

  // Shifter idle: load at a shift tick when data waits
  assign load = run & hold_q.loaded & (state_q == ast_pkg::AST_IDLE) & shift_tick;

  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hold_q <= '0;
    end else if (wr_data) begin
      // Ninth bit latched at write time; later writes to it do not reach this word
      hold_q.data   <= {ninth_data_bit_q, pwdata[7:0]};
      hold_q.loaded <= 1'b1;
    end else if (load) begin
      hold_q.loaded <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q        <= ast_pkg::AST_IDLE;
      tx_shift_reg_q <= 9'h000;
      bit_cnt_q      <= 4'h0;
      frame_bits_q   <= ast_pkg::BITS_EIGHT;
      tx_out_q       <= 1'b1;
    end else if (!run) begin
      state_q  <= ast_pkg::AST_IDLE;
      tx_out_q <= 1'b1;
    end else begin
      unique case (state_q)
        ast_pkg::AST_IDLE: begin
          tx_out_q <= 1'b1;
          if (load) begin
            tx_shift_reg_q <= hold_q.data;
            frame_bits_q   <= nine_bit_select_q ? ast_pkg::BITS_NINE : ast_pkg::BITS_EIGHT;
            tx_out_q       <= 1'b0;
            state_q        <= ast_pkg::AST_START;
          end
        end
        ast_pkg::AST_START: begin
          if (shift_tick) begin
            tx_out_q       <= tx_shift_reg_q[0];
            tx_shift_reg_q <= shr(tx_shift_reg_q);
            bit_cnt_q      <= 4'h1;
            state_q        <= ast_pkg::AST_DATA;
          end
        end
        ast_pkg::AST_DATA: begin
          if (shift_tick) begin
            if (bit_cnt_q == frame_bits_q) begin
              tx_out_q <= 1'b1;
              state_q  <= ast_pkg::AST_STOP;
            end else begin
              tx_out_q       <= tx_shift_reg_q[0];
              tx_shift_reg_q <= shr(tx_shift_reg_q);
              bit_cnt_q      <= bit_cnt_q + 4'h1;
            end
          end
        end
        ast_pkg::AST_STOP: begin
          if (shift_tick) begin
            state_q <= ast_pkg::AST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Status flags, one cycle behind the events; buffer-empty two cycles behind a load
  logic buf_empty_flag_q;
  logic shift_empty_q;
  logic en_d1_q;
  logic load_d1_q;

  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_d1_q          <= 1'b0;
      load_d1_q        <= 1'b0;
      buf_empty_flag_q <= 1'b0;
      shift_empty_q    <= 1'b1;
    end else begin
      en_d1_q   <= tx_enable_bit_q;
      load_d1_q <= load;
      // Set wins over the clearing write
      if (load_d1_q | (tx_enable_bit_q & ~en_d1_q & ~hold_q.loaded)) begin
        buf_empty_flag_q <= 1'b1;
      end else if (wr_data) begin
        buf_empty_flag_q <= 1'b0;
      end
      shift_empty_q <= (state_q == ast_pkg::AST_IDLE);
    end
  end

  // ==========================================================================
  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit(paddr, ast_pkg::ADDR_CTRL)) begin
      prdata[ast_pkg::CTRL_TX_ENABLE]  = tx_enable_bit_q;
      prdata[ast_pkg::CTRL_NINE_BIT]   = nine_bit_select_q;
      prdata[ast_pkg::CTRL_NINTH_DATA] = ninth_data_bit_q;
      prdata[ast_pkg::CTRL_HIGH_SPEED] = baud_high_speed_q;
      prdata[ast_pkg::CTRL_CLOCKED]    = clocked_mode_q;
      prdata[ast_pkg::CTRL_SHIFT_EMPT] = shift_empty_q;
    end else if (hit(paddr, ast_pkg::ADDR_DIVISOR)) begin
      prdata[7:0] = baud_divisor_q;
    end else if (hit(paddr, ast_pkg::ADDR_FLAGS)) begin
      prdata[ast_pkg::FLAG_BUF_EMPTY] = buf_empty_flag_q;
    end else if (hit(paddr, ast_pkg::ADDR_ENABLES)) begin
      prdata[ast_pkg::FLAG_BUF_EMPTY] = tx_irq_enable_q;
    end else if (hit(paddr, ast_pkg::ADDR_POWER)) begin
      prdata[ast_pkg::POWER_SLEEP] = sleep_q;
    end
  end

  assign o_tx_out = tx_out_q;
  assign o_tx_oe  = run;

  // ==========================================================================
  // Assertions
  a_abort_release: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    !run |-> !o_tx_oe ##1 state_q == ast_pkg::AST_IDLE)
    else $error("line driven while disabled");
  a_buf_flag_set: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    load |=> ##1 buf_empty_flag_q)
    else $error("buffer-empty flag late");
  a_shift_empty: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    load |=> ##1 !shift_empty_q)
    else $error("shift-empty not cleared");
  a_flag_clear: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    $fell(buf_empty_flag_q) |-> $past(wr_data))
    else $error("flag cleared without data write");
  a_start_low: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    load |=> !o_tx_out && state_q == ast_pkg::AST_START)
    else $error("start bit missing");
  a_idle_high: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    (state_q == ast_pkg::AST_IDLE && !load) |=> o_tx_out)
    else $error("line low while idle");
  a_lsb_first: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    (state_q == ast_pkg::AST_START && shift_tick && run)
      |=> o_tx_out == $past(tx_shift_reg_q[0]))
    else $error("first data bit not lsb");
  a_sleep_halt: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    sleep_q |-> !shift_tick)
    else $error("shift tick during sleep");
  a_enable_flag: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    $rose(tx_enable_bit_q) && !hold_q.loaded && !wr_data |=> buf_empty_flag_q)
    else $error("enable did not set flag");

  // ==========================================================================
  // Frame shape and status timing
  // The baud generator is the only timing source, so these pin down
  // what a frame looks like rather than how the counters get there.
  a_stop_high: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    state_q == ast_pkg::AST_STOP |-> o_tx_out)
    else $error("stop bit not high");

  a_data_count: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    state_q == ast_pkg::AST_DATA |-> (bit_cnt_q != 4'h0 && bit_cnt_q <= frame_bits_q))
    else $error("data bit count out of range");

  a_nine_len: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    load |=> frame_bits_q == ($past(nine_bit_select_q) ? ast_pkg::BITS_NINE
                                                        : ast_pkg::BITS_EIGHT))
    else $error("frame length does not follow nine-bit select");

  a_shift_empty_set: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    (state_q == ast_pkg::AST_STOP && shift_tick && run) |=> ##1 shift_empty_q)
    else $error("shift-empty not set after stop bit");

  // Sleep must freeze the frame where it stands, not just the ticks
  a_sleep_freeze: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    (sleep_q && run) |=> ($stable(state_q) && $stable(tx_shift_reg_q)))
    else $error("shifter moved during sleep");

  a_flag_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    (buf_empty_flag_q && !wr_data) |=> buf_empty_flag_q)
    else $error("buffer-empty flag cleared without data write");

  a_ninth_capture: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    wr_data |=> hold_q.data[8] == $past(ninth_data_bit_q))
    else $error("ninth bit not captured at data write");

  c_sleep_wait: cover property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    sleep_q && hold_q.loaded && state_q == ast_pkg::AST_IDLE);

  c_frame_done: cover property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    state_q == ast_pkg::AST_STOP && shift_tick);
  c_nine_bit: cover property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    load && nine_bit_select_q);
  c_abort: cover property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    state_q == ast_pkg::AST_DATA && $fell(tx_enable_bit_q));
  c_back_to_back: cover property (@(posedge i_ref_clk) disable iff (!rst_n_q)
    state_q == ast_pkg::AST_STOP && hold_q.loaded);

endmodule : ast_transmitter

`default_nettype wire

// >>> tb/ast_rx_model.sv
// Behavioural remote receiver that watches the serial line.
// Assumes the line is pulled high whenever the transmitter releases it.
`timescale 1ns/1ps
`default_nettype none

module ast_rx_model (
  input  wire logic        i_clk,      // Sampling clock
  input  wire logic        i_line,     // Resolved line level
  input  wire logic [15:0] i_bit_cyc,  // Clocks per bit
  input  wire logic        i_nine,     // Nine data bits per frame
  output var  logic [8:0]  o_word,     // Last word received
  output var  logic [15:0] o_count,    // Words received
  output var  logic [15:0] o_bad       // Frames with a low stop bit
);
  // ==========================================================================
  // Frame sampler
  logic [8:0] w;
  int         nb;

  // Falling edge sampling keeps clear of the transmitter's flop updates
  initial begin
    o_word  = 9'h000;
    o_count = 16'h0000;
    o_bad   = 16'h0000;
    forever begin
      @(negedge i_clk);
      if (i_line === 1'b0) begin
        w  = 9'h000;
        nb = i_nine ? 9 : 8;
        repeat (i_bit_cyc / 2) @(negedge i_clk);
        for (int i = 0; i < nb; i++) begin
          repeat (i_bit_cyc) @(negedge i_clk);
          w[i] = i_line;
        end
        repeat (i_bit_cyc) @(negedge i_clk);
        if (i_line !== 1'b1) o_bad = o_bad + 16'h0001;
        o_word  = w;
        o_count = o_count + 16'h0001;
      end
    end
  end
endmodule : ast_rx_model

`default_nettype wire

// >>> tb/tb_async_serial_transmitter.sv
// Self-checking bench for the serial transmitter, driven over APB.
// Assumes a pull-up on the line and the behavioural receiver beside it.
`timescale 1ns/1ps
`default_nettype none

module tb_async_serial_transmitter;
  localparam logic [31:0] EN = 32'h1 << ast_pkg::CTRL_TX_ENABLE;
  localparam logic [31:0] HS = 32'h1 << ast_pkg::CTRL_HIGH_SPEED;
  localparam logic [31:0] NB = 32'h1 << ast_pkg::CTRL_NINE_BIT;
  localparam logic [31:0] ND = 32'h1 << ast_pkg::CTRL_NINTH_DATA;
  localparam logic [31:0] CK = 32'h1 << ast_pkg::CTRL_CLOCKED;
  localparam logic [31:0] SE = 32'h1 << ast_pkg::CTRL_SHIFT_EMPT;
  localparam logic [31:0] BE = 32'h1 << ast_pkg::FLAG_BUF_EMPTY;

  logic        i_ref_clk;
  logic        i_nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        o_tx_out;
  logic        o_tx_oe;
  wire logic   line;
  logic [15:0] bit_cyc;
  logic        nine;
  logic [8:0]  rx_word;
  logic [15:0] rx_count;
  logic [15:0] rx_bad;
  logic [31:0] rdat;
  logic        rerr;
  logic [15:0] nrx;
  int          err_total;
  int          checks;

  // Released line floats up to the idle level
  assign line = o_tx_oe ? o_tx_out : 1'b1;

  ast_transmitter u_ast_transmitter (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .o_tx_out(o_tx_out), .o_tx_oe(o_tx_oe));

  ast_rx_model u_ast_rx_model (.i_clk(i_ref_clk), .i_line(line), .i_bit_cyc(bit_cyc),
    .i_nine(nine), .o_word(rx_word), .o_count(rx_count), .o_bad(rx_bad));

  // ==========================================================================
  // Clock, closing and watchdog
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge i_ref_clk);
    err_total++;
    report_and_stop();
  end

  // ==========================================================================
  // Bus and comparison tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    // Answer taken at the rising edge that sees pready high
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rdat, exp);
  endtask : rd

  // Checks drive enable and line level together, away from the edge
  task automatic pin(input logic [31:0] exp);
    @(negedge i_ref_clk);
    cmp({30'h0, o_tx_oe, line}, exp);
    @(posedge i_ref_clk);
  endtask : pin

  task automatic wait_rx(input logic [15:0] n, input logic [8:0] w);
    int k;
    k = 0;
    while (rx_count !== n && k < 20000) begin
      @(posedge i_ref_clk);
      k++;
    end
    cmp({16'h0, rx_count}, {16'h0, n});
    cmp({23'h0, rx_word}, {23'h0, w});
  endtask : wait_rx

  // ==========================================================================
  // Scenarios
  initial begin
    i_nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; bit_cyc = 16'h0010; nine = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    rd(ast_pkg::ADDR_CTRL, {24'h0, ast_pkg::CTRL_RESET});
    rd(ast_pkg::ADDR_FLAGS, 32'h0);
    pin(32'h1);
    apb(1'b0, 8'h18, 32'h0);
    cmp({31'h0, rerr}, 32'h1);
    cmp(rdat, 32'h0);
    wr(ast_pkg::ADDR_ENABLES, BE);
    rd(ast_pkg::ADDR_ENABLES, BE);
    // Divisor 0 at x16 gives 16 clocks per bit
    wr(ast_pkg::ADDR_DIVISOR, 32'h0);
    wr(ast_pkg::ADDR_CTRL, EN | HS);
    rd(ast_pkg::ADDR_FLAGS, BE);
    pin(32'h3);
    wr(ast_pkg::ADDR_DATA, 32'hA5);
    repeat (20) @(posedge i_ref_clk);
    rd(ast_pkg::ADDR_CTRL, EN | HS);
    rd(ast_pkg::ADDR_FLAGS, BE);
    wr(ast_pkg::ADDR_DATA, 32'h3C);
    rd(ast_pkg::ADDR_FLAGS, 32'h0);
    wait_rx(16'h0001, 9'h0A5);
    wait_rx(16'h0002, 9'h03C);
    wr(ast_pkg::ADDR_FLAGS, 32'h0);
    rd(ast_pkg::ADDR_FLAGS, BE);
    repeat (20) @(posedge i_ref_clk);
    rd(ast_pkg::ADDR_CTRL, EN | HS | SE);
    // Nine bits at x64, divisor 1; data written before enable
    wr(ast_pkg::ADDR_CTRL, 32'h0);
    bit_cyc <= 16'h0080;
    nine    <= 1'b1;
    wr(ast_pkg::ADDR_DIVISOR, 32'h1);
    wr(ast_pkg::ADDR_CTRL, NB | ND);
    wr(ast_pkg::ADDR_DATA, 32'h55);
    rd(ast_pkg::ADDR_FLAGS, 32'h0);
    wr(ast_pkg::ADDR_CTRL, EN | NB | ND);
    wait_rx(16'h0003, 9'h155);
    // Sleep halts the baud generator, so nothing starts; stop bit ends first
    repeat (100) @(posedge i_ref_clk);
    wr(ast_pkg::ADDR_POWER, 32'h1);
    wr(ast_pkg::ADDR_DATA, 32'hAA);
    repeat (600) @(posedge i_ref_clk);
    cmp({16'h0, rx_count}, 32'h3);
    rd(ast_pkg::ADDR_CTRL, EN | NB | ND | SE);
    wr(ast_pkg::ADDR_POWER, 32'h0);
    wait_rx(16'h0004, 9'h1AA);
    // Abort in mid-frame
    wr(ast_pkg::ADDR_DATA, 32'h00);
    repeat (400) @(posedge i_ref_clk);
    wr(ast_pkg::ADDR_CTRL, NB | ND);
    pin(32'h1);
    rd(ast_pkg::ADDR_CTRL, NB | ND | SE);
    repeat (2000) @(posedge i_ref_clk);
    nrx  = rx_count;
    nine <= 1'b0;
    wr(ast_pkg::ADDR_CTRL, EN);
    wr(ast_pkg::ADDR_DATA, 32'h81);
    wait_rx(nrx + 16'h0001, 9'h081);
    cmp({16'h0, rx_bad}, 32'h0);
    // Clocked mode keeps the line released
    wr(ast_pkg::ADDR_CTRL, EN | CK);
    pin(32'h1);
    report_and_stop();
  end
endmodule : tb_async_serial_transmitter

`default_nettype wire
